// ==== core/tlpi_regs.svh ====
/*
 Register offsets, field positions, vector addresses and timing counts of the
 two-level priority interrupt unit. Assumes a plain 8-bit word port.
*/
`ifndef TLPI_REGS_SVH
`define TLPI_REGS_SVH

`define TLPI_NSRC           8
`define TLPI_NPIN           3
`define TLPI_VEC_HIGH       21'h000008
`define TLPI_VEC_LOW        21'h000018
`define TLPI_ADDR_CTRL      4'h0
`define TLPI_ADDR_FLAG      4'h1
`define TLPI_ADDR_ENABLE    4'h2
`define TLPI_ADDR_LEVEL     4'h3
`define TLPI_ADDR_STAT      4'h4
`define TLPI_ADDR_MASK      4'h5
`define TLPI_ADDR_RETADR    4'h6
`define TLPI_CTRL_GIE       0
`define TLPI_CTRL_PERIPHERAL_GROUP_ENABLE      1
`define TLPI_CTRL_LVLMODE   2
`define TLPI_STAT_TAKE_HI   0
`define TLPI_STAT_TAKE_LO   1
`define TLPI_STAT_RETURN    2
`define TLPI_LAT_CYCLES     3'h3
`define TLPI_STACK_DEPTH    31

`endif

// ==== core/tlpi_pkg.sv ====
/*
 Types of the two-level priority interrupt unit.
 Assumes tlpi_regs.svh is on the include path.
*/
`default_nettype none
`include "tlpi_regs.svh"
package tlpi_pkg;
   typedef struct packed {
      logic level_mode_enable;
      logic peripheral_group_enable;
      logic global_irq_enable;
   } tlpi_ctrl_t;
   typedef struct packed {
      logic        valid;
      logic [20:0] target;
   } tlpi_jump_t;
   typedef enum logic [2:0] {
      TLPI_RUN   = 3'h1,
      TLPI_HIGH  = 3'h2,
      TLPI_BOTH  = 3'h4
   } tlpi_svc_t;
endpackage : tlpi_pkg
`default_nettype wire

// ==== core/tlpi_pin_sync.sv ====
/*
 Two-flop synchroniser and rising-edge detector for external event pins.
 Assumes pins are asynchronous to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tlpi_regs.svh"
module tlpi_pin_sync (
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   input  wire logic [`TLPI_NPIN-1:0]  pin_in,
   output logic      [`TLPI_NPIN-1:0]  event_out
);
   logic [`TLPI_NPIN-1:0] s1_q;
   logic [`TLPI_NPIN-1:0] s2_q;
   logic [`TLPI_NPIN-1:0] s3_q;
   logic [`TLPI_NPIN-1:0] rise_w;

   assign rise_w = s2_q & ~s3_q;
   // Edge goes straight on; the flag register is the next stage
   assign event_out = rise_w;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q      <= '0;
         s2_q      <= '0;
         s3_q      <= '0;
      end else begin
         s1_q      <= pin_in;
         s2_q      <= s1_q;
         s3_q      <= s2_q;
      end
   end
endmodule : tlpi_pin_sync
`default_nettype wire

// ==== core/tlpi_unit.sv ====
/*
 Two-level priority interrupt unit: flags, enables, level selects,
 vectoring, return-address stack and a small status/mask block.
 Assumes the core sequencer follows vector_out and pulses return_from_irq_instr_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tlpi_regs.svh"
module tlpi_unit (
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   input  wire logic [3:0]             addr_in,
   input  wire logic [7:0]             wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [7:0]             rdata_out,
   input  wire logic [`TLPI_NPIN-1:0]  pin_in,
   input  wire logic [`TLPI_NSRC-1:0]  periph_event_in,
   input  wire logic [20:0]            pc_in,
   input  wire logic                   return_from_irq_instr_in,
   output logic                        jump_out,
   output logic      [20:0]            vector_out,
   output logic      [20:0]            return_addr_out,
   output logic                        irq_out
);
   localparam int NS = `TLPI_NSRC;

   logic [NS-1:0]         flag_q;
   logic [NS-1:0]         en_q;
   logic [NS-1:0]         lvl_q;
   logic                  gie_q;
   logic                  peripheral_group_enable_q;
   logic                  level_mode_enable_q;
   logic [2:0]            stat_q;
   logic [2:0]            mask_q;
   logic                  jump_q;
   logic [20:0]           vec_q;
   logic [20:0]           ret_q;
   logic                  irq_q;
   logic [7:0]            rdata_q;
   logic [20:0]           stack_q [`TLPI_STACK_DEPTH];
   logic [4:0]            sp_q;
   logic [1:0]            lvl_stk_q;
   tlpi_pkg::tlpi_svc_t   svc_q;
   tlpi_pkg::tlpi_ctrl_t  ctrl_w;
   logic [`TLPI_NPIN-1:0] pin_ev_w;
   logic [NS-1:0]         ev_w;
   logic [NS-1:0]         flag_d;
   logic [NS-1:0]         act_w;
   logic [NS-1:0]         periph_w;
   logic                  hi_req_w;
   logic                  lo_req_w;
   logic                  take_hi_w;
   logic                  take_lo_w;
   logic                  take_w;
   logic                  ret_w;
   logic                  ret_lo_w;
   logic                  wr_ctrl_w;
   logic                  wr_flag_w;
   logic                  wr_en_w;
   logic                  wr_lvl_w;
   logic                  wr_stat_w;
   logic                  wr_mask_w;
   logic                  hi_two_w;
   logic                  hi_one_w;
   logic [2:0]            stat_set_w;
   tlpi_pkg::tlpi_jump_t  jmp_w;

   function automatic logic [7:0] pad8(input logic [2:0] v);
      pad8 = {5'h00, v};
   endfunction : pad8

   function automatic logic wr_hit(input logic       wr,
                                   input logic [3:0] addr,
                                   input logic [3:0] hit);
      wr_hit = wr && addr == hit;
   endfunction : wr_hit

   tlpi_pin_sync u_pins (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .pin_in    (pin_in),
      .event_out (pin_ev_w)
   );

   assign ctrl_w    = '{level_mode_enable_q, peripheral_group_enable_q, gie_q};
   // Low sources are the pins; the rest are peripherals
   assign periph_w  = {{(NS-`TLPI_NPIN){1'b1}}, {`TLPI_NPIN{1'b0}}};
   assign ev_w      = periph_event_in | {{(NS-`TLPI_NPIN){1'b0}}, pin_ev_w};
   assign act_w     = flag_q & en_q;
   assign wr_ctrl_w = wr_hit(wr_in, addr_in, `TLPI_ADDR_CTRL);
   assign wr_flag_w = wr_hit(wr_in, addr_in, `TLPI_ADDR_FLAG);
   assign wr_en_w   = wr_hit(wr_in, addr_in, `TLPI_ADDR_ENABLE);
   assign wr_lvl_w  = wr_hit(wr_in, addr_in, `TLPI_ADDR_LEVEL);
   assign wr_stat_w = wr_hit(wr_in, addr_in, `TLPI_ADDR_STAT);
   assign wr_mask_w = wr_hit(wr_in, addr_in, `TLPI_ADDR_MASK);

   assign hi_two_w  = |(act_w & lvl_q) && gie_q;
   assign hi_one_w  = gie_q && |(act_w & (~periph_w | {NS{peripheral_group_enable_q}}));
   assign hi_req_w  = ctrl_w.level_mode_enable ? hi_two_w : hi_one_w;
   assign lo_req_w  = ctrl_w.level_mode_enable
      && |(act_w & ~lvl_q) && peripheral_group_enable_q;
   assign take_hi_w = hi_req_w && !jump_q;
   assign take_lo_w = lo_req_w && !hi_req_w && !jump_q;
   assign take_w    = take_hi_w || take_lo_w;
   assign ret_w     = return_from_irq_instr_in && sp_q != 5'h00;
   assign ret_lo_w  = lvl_stk_q[0];

   assign jmp_w.valid  = take_w;
   assign jmp_w.target = take_lo_w ? `TLPI_VEC_LOW : `TLPI_VEC_HIGH;

   assign flag_d = wr_flag_w ? ((flag_q & wdata_in) | ev_w)
                             : (flag_q | ev_w);

   assign stat_set_w = {ret_w, take_lo_w, take_hi_w};

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         flag_q <= '0;
         en_q   <= '0;
         lvl_q  <= '1;
      end else begin
         flag_q <= flag_d;
         if (wr_en_w) begin
            en_q <= wdata_in;
         end
         if (wr_lvl_w) begin
            lvl_q <= wdata_in;
         end
      end
   end

   // Group enables: software write, cleared on take, set on return
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         gie_q  <= 1'b0;
         peripheral_group_enable_q <= 1'b0;
         level_mode_enable_q <= 1'b0;
      end else begin
         if (wr_ctrl_w) begin
            gie_q  <= wdata_in[`TLPI_CTRL_GIE];
            peripheral_group_enable_q <= wdata_in[`TLPI_CTRL_PERIPHERAL_GROUP_ENABLE];
            level_mode_enable_q <= wdata_in[`TLPI_CTRL_LVLMODE];
         end
         if (ret_w) begin
            if (level_mode_enable_q && ret_lo_w) begin
               peripheral_group_enable_q <= 1'b1;
            end else begin
               gie_q <= 1'b1;
            end
         end
         if (take_hi_w) begin
            gie_q <= 1'b0;
         end else if (take_lo_w) begin
            peripheral_group_enable_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sp_q      <= 5'h00;
         lvl_stk_q <= 2'h0;
         jump_q    <= 1'b0;
         vec_q     <= 21'h000000;
         ret_q     <= 21'h000000;
      end else begin
         jump_q <= jmp_w.valid;
         if (jmp_w.valid) begin
            vec_q <= jmp_w.target;
         end
         if (take_w && sp_q != 5'(`TLPI_STACK_DEPTH)) begin
            sp_q      <= sp_q + 5'h01;
            lvl_stk_q <= {lvl_stk_q[0], take_lo_w};
         end else if (ret_w) begin
            sp_q      <= sp_q - 5'h01;
            lvl_stk_q <= {1'b0, lvl_stk_q[1]};
            ret_q     <= stack_q[sp_q - 5'h01];
         end
      end
   end

   // Stack array has no reset; only filled entries are read
   always_ff @(posedge clock_in) begin
      if (take_w && sp_q != 5'(`TLPI_STACK_DEPTH)) begin
         stack_q[sp_q] <= pc_in;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         svc_q <= tlpi_pkg::TLPI_RUN;
      end else begin
         case (svc_q)
            tlpi_pkg::TLPI_RUN: begin
               if (take_w) begin
                  svc_q <= tlpi_pkg::TLPI_HIGH;
               end
            end
            tlpi_pkg::TLPI_HIGH: begin
               if (take_hi_w) begin
                  svc_q <= tlpi_pkg::TLPI_BOTH;
               end else if (ret_w) begin
                  svc_q <= tlpi_pkg::TLPI_RUN;
               end
            end
            tlpi_pkg::TLPI_BOTH: begin
               if (ret_w) begin
                  svc_q <= tlpi_pkg::TLPI_HIGH;
               end
            end
            default: begin
               svc_q <= tlpi_pkg::TLPI_RUN;
            end
         endcase
      end
   end

   // Status: set wins over write-one-to-clear
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stat_q <= 3'h0;
         mask_q <= 3'h0;
         irq_q  <= 1'b0;
      end else begin
         if (wr_stat_w) begin
            stat_q <= (stat_q & ~wdata_in[2:0]) | stat_set_w;
         end else begin
            stat_q <= stat_q | stat_set_w;
         end
         if (wr_mask_w) begin
            mask_q <= wdata_in[2:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `TLPI_ADDR_CTRL:   rdata_q <= pad8({level_mode_enable_q, peripheral_group_enable_q, gie_q});
            `TLPI_ADDR_FLAG:   rdata_q <= flag_q;
            `TLPI_ADDR_ENABLE: rdata_q <= en_q;
            `TLPI_ADDR_LEVEL:  rdata_q <= lvl_q;
            `TLPI_ADDR_STAT:   rdata_q <= pad8(stat_q);
            `TLPI_ADDR_MASK:   rdata_q <= pad8(mask_q);
            `TLPI_ADDR_RETADR: rdata_q <= {3'h0, sp_q};
            default:           rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata_out       = rdata_q;
   assign jump_out        = jump_q;
   assign vector_out      = vec_q;
   assign return_addr_out = ret_q;
   assign irq_out         = irq_q;

   // Take leads to a one-cycle jump pulse
   AST_TAKE_JUMP: assert property (
      @(posedge clock_in) disable iff (rst_in)
      take_w |=> jump_out)
      else $error("take without jump");
   AST_ONE_JUMP: assert property (
      @(posedge clock_in) disable iff (rst_in)
      jump_out |=> !jump_out)
      else $error("jump pulse too long");
   AST_HI_VEC: assert property (
      @(posedge clock_in) disable iff (rst_in)
      take_hi_w |=> vector_out == `TLPI_VEC_HIGH)
      else $error("high vec");
   AST_LOW_VEC: assert property (
      @(posedge clock_in) disable iff (rst_in)
      take_lo_w |=> vector_out == `TLPI_VEC_LOW)
      else $error("low vec");
   AST_SINGLE_VEC: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (take_w && !level_mode_enable_q) |=> vector_out == `TLPI_VEC_HIGH)
      else $error("single mode vec");
   AST_SINGLE_NO_LO: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !level_mode_enable_q |-> !take_lo_w)
      else $error("low take in single mode");
   AST_HI_GATE: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (take_hi_w && level_mode_enable_q) |-> gie_q && |(act_w & lvl_q))
      else $error("high take not allowed");
   AST_LO_GATE: assert property (
      @(posedge clock_in) disable iff (rst_in)
      take_lo_w |-> peripheral_group_enable_q && |(act_w & ~lvl_q))
      else $error("low take not allowed");
   AST_PERIPH_GATE: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (!level_mode_enable_q && !peripheral_group_enable_q && !(|(act_w & ~periph_w))) |-> !take_w)
      else $error("peripheral take while gated");
   AST_CLR_GIE: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (take_hi_w && !wr_ctrl_w) |=> !gie_q)
      else $error("gie kept");
   AST_CLR_LO: assert property (
      @(posedge clock_in) disable iff (rst_in)
      take_lo_w |=> !peripheral_group_enable_q)
      else $error("low enable kept");
   AST_PUSH: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (take_w && sp_q < 5'h1e) |=> sp_q == $past(sp_q) + 5'h01)
      else $error("no push");
   AST_POP: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (ret_w && !take_w) |=> sp_q == $past(sp_q) - 5'h01)
      else $error("no pop");
   AST_RET_EN: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (ret_w && !take_w && !wr_ctrl_w && !level_mode_enable_q) |=> gie_q)
      else $error("return left gie off");
   AST_RET_LO: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (ret_w && level_mode_enable_q && ret_lo_w && !take_lo_w && !wr_ctrl_w) |=> peripheral_group_enable_q)
      else $error("return left low enable off");
   AST_FLAG_SET: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (|ev_w) |=> ((flag_q & $past(ev_w)) == $past(ev_w)))
      else $error("flag lost");
   AST_FLAG_KEEP: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !wr_flag_w |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
      else $error("flag cleared without write");
   AST_HI_FIRST: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (hi_req_w && lo_req_w && !jump_q) |-> take_hi_w && !take_lo_w)
      else $error("low before high");
   AST_NEST_DEPTH: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (svc_q == tlpi_pkg::TLPI_BOTH) |-> sp_q >= 5'h02)
      else $error("nested service without two pushes");
endmodule : tlpi_unit
`default_nettype wire

// ==== sim/tlpi_core_model.sv ====
/*
 Core sequencer model: program counter, vector load, return pulses.
 Assumes the unit pulses jump_in for one cycle per take.
*/
`timescale 1ns/1ps
`default_nettype none
module tlpi_core_model (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        jump_in,
   input  wire logic [20:0] vector_in,
   input  wire logic        ret_cmd_in,
   output logic      [20:0] pc_out,
   output logic      [20:0] take_pc_out,
   output logic             return_out
);
   logic [20:0] pc_prev_q;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pc_out      <= 21'h000100;
         pc_prev_q   <= 21'h000100;
         take_pc_out <= 21'h000000;
         return_out  <= 1'b0;
      end else begin
         pc_prev_q  <= pc_out;
         return_out <= ret_cmd_in;
         if (jump_in) begin
            pc_out      <= vector_in;
            take_pc_out <= pc_prev_q;
         end else begin
            pc_out <= pc_out + 21'h000001;
         end
      end
   end
endmodule : tlpi_core_model
`default_nettype wire

// ==== sim/tlpi_unit_tb.sv ====
/*
 Bench for tlpi_unit: table of enable cases, nesting, ties, reset, pins.
 Assumes tlpi_core_model stands in for the core.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tlpi_regs.svh"
module tlpi_unit_tb;
   typedef struct packed {
      logic [7:0]  ctrl, en, lvl, src, after;
      logic        jmp;
      logic [20:0] vec;
   } tlpi_row_t;
   logic        clock_in = 1'b0, rst_in = 1'b1;
   logic        wr = 1'b0, rd = 1'b0, retcmd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, pev = 8'h00, rdata;
   logic [2:0]  pin = 3'h0;
   logic [20:0] pc, vec, raddr, tpc, v, d;
   logic        jump, ret, irq, got;
   logic [20:0] stk[$];
   int          bad_count = 0, tests_run = 0, n;
   // Ctrl, enable, level, event, ctrl after, jump, vector
   tlpi_row_t rows[7] = '{
      '{8'h03, 8'h08, 8'h00, 8'h08, 8'h02, 1'b1, 21'h000008},
      '{8'h01, 8'h08, 8'h00, 8'h08, 8'h01, 1'b0, 21'h000000},
      '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 1'b1, 21'h000008},
      '{8'h05, 8'h08, 8'h08, 8'h08, 8'h04, 1'b1, 21'h000008},
      '{8'h06, 8'h08, 8'h00, 8'h08, 8'h04, 1'b1, 21'h000018},
      '{8'h05, 8'h08, 8'h00, 8'h08, 8'h05, 1'b0, 21'h000000},
      '{8'h03, 8'h00, 8'h00, 8'h08, 8'h03, 1'b0, 21'h000000}};
   always #50 clock_in = ~clock_in;
   tlpi_unit dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .pin_in(pin), .periph_event_in(pev), .pc_in(pc),
      .return_from_irq_instr_in(ret), .jump_out(jump), .vector_out(vec),
      .return_addr_out(raddr), .irq_out(irq));
   tlpi_core_model core (.clock_in(clock_in), .rst_in(rst_in),
      .jump_in(jump), .vector_in(vec), .ret_cmd_in(retcmd), .pc_out(pc),
      .take_pc_out(tpc), .return_out(ret));
   task automatic chk(input logic [20:0] s, input logic [20:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wrr(input logic [3:0] a, input logic [7:0] x);
      @(posedge clock_in);
      addr  <= a;
      wdata <= x;
      wr    <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask : wrr
   task automatic rdr(input logic [3:0] a);
      @(posedge clock_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 d = {13'h0000, rdata};
   endtask : rdr
   task automatic ev(input logic [7:0] s);
      @(posedge clock_in);
      pev <= s;
      @(posedge clock_in);
      pev <= 8'h00;
   endtask : ev
   // Bounded wait for a take; records the core's return address
   task automatic wj();
      got = 1'b0;
      v   = 21'h000000;
      for (int i = 0; i < 6 && !got; i++) begin
         @(posedge clock_in);
         #1;
         if (jump === 1'b1) begin
            got = 1'b1;
            v   = vec;
            @(posedge clock_in);
            #1 stk.push_back(tpc);
         end
      end
   endtask : wj
   task automatic rt();
      @(posedge clock_in);
      retcmd <= 1'b1;
      @(posedge clock_in);
      retcmd <= 1'b0;
      @(posedge clock_in);
      #1 chk(raddr, stk.pop_back());
   endtask : rt
   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge clock_in);
      bad_count++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      foreach (rows[i]) begin
         wrr(`TLPI_ADDR_CTRL, 8'h00);
         wrr(`TLPI_ADDR_FLAG, 8'h00);
         wrr(`TLPI_ADDR_ENABLE, rows[i].en);
         wrr(`TLPI_ADDR_LEVEL, rows[i].lvl);
         wrr(`TLPI_ADDR_CTRL, rows[i].ctrl);
         ev(rows[i].src);
         wj();
         chk(got, rows[i].jmp);
         chk(v, rows[i].vec);
         rdr(`TLPI_ADDR_FLAG);
         chk(d, rows[i].src);
         rdr(`TLPI_ADDR_CTRL);
         chk(d, rows[i].after);
         if (got) begin
            wrr(`TLPI_ADDR_FLAG, 8'h00);
            rt();
            rdr(`TLPI_ADDR_CTRL);
            chk(d, rows[i].ctrl);
         end
      end
      // Low service preempted by a high event, then unwound
      wrr(`TLPI_ADDR_FLAG, 8'h00);
      wrr(`TLPI_ADDR_STAT, 8'h07);
      wrr(`TLPI_ADDR_ENABLE, 8'h18);
      wrr(`TLPI_ADDR_LEVEL, 8'h08);
      wrr(`TLPI_ADDR_MASK, 8'h03);
      wrr(`TLPI_ADDR_CTRL, 8'h07);
      ev(8'h10);
      wj();
      chk(v, `TLPI_VEC_LOW);
      rdr(`TLPI_ADDR_CTRL);
      chk(d, 21'h000005);
      ev(8'h08);
      wj();
      chk(v, `TLPI_VEC_HIGH);
      rdr(`TLPI_ADDR_STAT);
      chk(d, 21'h000003);
      chk(irq, 1'b1);
      wrr(`TLPI_ADDR_STAT, 8'h03);
      repeat (2) @(posedge clock_in);
      #1 chk(irq, 1'b0);
      wrr(`TLPI_ADDR_FLAG, 8'h00);
      rt();
      rt();
      rdr(`TLPI_ADDR_CTRL);
      chk(d, 21'h000007);
      rdr(`TLPI_ADDR_STAT);
      chk(d, 21'h000004);
      // Tie goes high; status masked keeps the line low
      wrr(`TLPI_ADDR_MASK, 8'h00);
      ev(8'h18);
      wj();
      chk(v, `TLPI_VEC_HIGH);
      chk(irq, 1'b0);
      // Second reset mid-run
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      stk.delete();
      rdr(`TLPI_ADDR_CTRL);
      chk(d, 21'h000000);
      rdr(`TLPI_ADDR_LEVEL);
      chk(d, 21'h0000ff);
      rdr(`TLPI_ADDR_RETADR);
      chk(d, 21'h000000);
      rdr(4'hf);
      chk(d, 21'h000000);
      wrr(`TLPI_ADDR_ENABLE, 8'h01);
      wrr(`TLPI_ADDR_CTRL, 8'h01);
      @(posedge clock_in);
      pin <= 3'h1;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
         #1;
      end while (jump !== 1'b1 && n < 10);
      chk(n >= 3 && n <= 4, 1'b1);
      test_done();
   end
endmodule : tlpi_unit_tb
`default_nettype wire
